// >>> rtl/fspc_pkg.sv
// Types shared by the pipeline control block
package fspc_pkg;
    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_ADD = 6'h01, OP_SUB = 6'h02, OP_AND = 6'h03,
        OP_OR = 6'h04, OP_ADDI = 6'h05, OP_LW = 6'h06, OP_LH = 6'h07,
        OP_LB = 6'h08, OP_SW = 6'h09, OP_BEQ = 6'h0A, OP_BNE = 6'h0B,
        OP_MULG = 6'h0C, OP_MULT = 6'h0D, OP_MAC = 6'h0E, OP_DIV = 6'h0F,
        OP_MFHI = 6'h10, OP_MFLO = 6'h11
    } fspc_op_e;
    typedef enum logic [1:0] {
        MD_DSP = 2'h0, MD_HIPERF = 2'h1, MD_AREA = 2'h2
    } fspc_mode_e;
    typedef enum logic [1:0] {
        MS_IDLE = 2'h0, MS_MEM = 2'h1, MS_ALIGN = 2'h3
    } fspc_mdst_e;
    typedef struct packed {
        logic        v;
        fspc_op_e    op;
        logic [4:0]  rd;
        logic [4:0]  rs;
        logic [4:0]  rt;
        logic [31:0] imm;
        logic [31:0] pc;
    } fspc_dec_s;
    typedef struct packed {
        logic        v;
        fspc_op_e    op;
        logic [4:0]  rd;
        logic [31:0] res;
        logic [31:0] addr;
        logic [31:0] opb;
    } fspc_stg_s;
endpackage : fspc_pkg

// >>> rtl/fspc_regs.svh
// Offsets, fields, reset values and stall counts
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH
`define FSPC_CTRL_OFS      8'h00
`define FSPC_STAT_OFS      8'h04
`define FSPC_PC_OFS        8'h08
`define FSPC_BKA_OFS       8'h0C
`define FSPC_BKD_OFS       8'h10
`define FSPC_HI_OFS        8'h14
`define FSPC_LO_OFS        8'h18
`define FSPC_CTRL_RUN      0
`define FSPC_CTRL_BASE     1
`define FSPC_CTRL_CMPT     2
`define FSPC_CTRL_MODE_LO  3
`define FSPC_CTRL_MODE_HI  4
`define FSPC_CTRL_BKEN     5
`define FSPC_CTRL_RST      32'h0000000A
`define FSPC_STAT_BRK      0
`define FSPC_STAT_MDBUSY   1
`define FSPC_STAT_STALL    2
`define FSPC_BOOT_PC       32'h80000000
`define FSPC_KSEG_MASK     32'h1FFFFFFF
`define FSPC_USEG_OFS      32'h40000000
`define FSPC_HP_MUL32      6'h01
`define FSPC_AREA_MUL      6'h1F
`define FSPC_AREA_MAC      6'h21
`define FSPC_DIV_MAX       6'h26
`define FSPC_SKIP_1B       6'h07
`define FSPC_SKIP_2B       6'h0F
`define FSPC_SKIP_3B       6'h17
`endif

// >>> rtl/fspc_top.sv
// Five-stage integer pipeline control with muldiv_unit and bus registers
//
// Operation
// [RULE1] Instructions flow fetch, execute, memory, align, writeback in order.
// [RULE2] Results bypass to dependent instructions.
// [RULE3] Fetch reads the next word from instruction SRAM.
// [RULE4] Base plus compact: compact words become base-like in fetch.
// [RULE5] Compact-only: 16-bit words expand to 32-bit compact form.
// [RULE6] Execute reads operands, bypassing memory and align results.
// [RULE7] Execute forms and translates the load/store address.
// [RULE8] Execute resolves branches and computes their target.
// [RULE9] Execute selects next fetch address and translates it.
// [RULE10] Every multiply and divide starts in execute.
// [RULE11] Memory stage finishes ALU work and accesses data SRAM.
// [RULE12] DSP option: a 32x32 multiply finishes within the memory stage.
// [RULE13] Hiperf option: 32x32 multiply holds muldiv_unit one extra clock.
// [RULE14] Area option: multiply holds muldiv_unit 31 clocks in memory stage.
// [RULE15] Area option: multiply-accumulate holds muldiv_unit 33 clocks.
// [RULE16] Divide holds muldiv_unit in memory stage at most 38 clocks.
// [RULE17] Fast divider skips 7, 15 or 23 clocks on sign-extension bytes; code skips only when the upper bytes of opa are zero.
// [RULE18] Align stage aligns load data before writeback.
// [RULE19] Area option: muldiv results enter mdu_result_pair in align stage.
// [RULE20] Hiperf option: final product add in align, register write later.
// [RULE21] gpr_multiply product is ready at align and committed at writeback.
// [RULE22] Complex breakpoints are evaluated in align.
// [RULE23] Writeback stores register and load results into the register file.
// [RULE24] muldiv_unit keeps advancing while the integer_pipeline is stalled.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fspc_regs.svh"
module fspc_top (
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP,
    output logic [31:0]      I_ADDR,
    input  wire logic [31:0] I_RDATA,
    output logic             D_REQ,
    output logic             D_WE,
    output logic [3:0]       D_BE,
    output logic [31:0]      D_ADDR,
    output logic [31:0]      D_WDATA,
    input  wire logic [31:0] D_RDATA,
    output logic             BREAK_FLAG,
    output logic             MDU_BUSY
);
    import fspc_pkg::*;

    // Fixed mapping of kernel and user windows
    function automatic logic [31:0] xlate(input logic [31:0] va);
        if (va[31:30] == 2'h2) begin
            xlate = va & `FSPC_KSEG_MASK;
        end else if (!va[31]) begin
            xlate = va + `FSPC_USEG_OFS;
        end else begin
            xlate = va;
        end
    endfunction : xlate

    function automatic logic writes(input fspc_op_e op);
        writes = (op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_ADDI, OP_LW, OP_LH,
                             OP_LB, OP_MULG, OP_MFHI, OP_MFLO});
    endfunction : writes

    function automatic logic is_load(input fspc_op_e op);
        is_load = (op inside {OP_LW, OP_LH, OP_LB});
    endfunction : is_load

    // Decode a fetched word into common fields
    function automatic fspc_dec_s decode(input logic [31:0] word, input logic cmpt,
                                         input logic base, input logic [31:0] pc);
        logic [31:0] w;
        logic        native;
        w = word;
        native = cmpt && !base;
        decode = '0;
        if (cmpt && word[31:16] == 16'h0000) begin
            if (base) begin
                // Compact to base-like
                w = {2'b00, word[15:12], 2'b01, word[11:9], 2'b01, word[8:6],
                     2'b01, word[2:0], {5{word[5]}}, word[5:0]}; // [RULE4]
            end else begin
                // Recode to 32-bit compact
                w = {{5{word[5]}}, word[5:0], 2'b01, word[2:0], 2'b01, word[8:6],
                     2'b01, word[11:9], 2'b00, word[15:12]}; // [RULE5]
            end
        end
        if (native) begin
            decode.op  = fspc_op_e'(w[5:0]); // [RULE5]
            decode.rd  = w[10:6];
            decode.rs  = w[15:11];
            decode.rt  = w[20:16];
            decode.imm = {{21{w[31]}}, w[31:21]};
        end else begin
            decode.op  = fspc_op_e'(w[31:26]);
            decode.rd  = w[25:21];
            decode.rs  = w[20:16];
            decode.rt  = w[15:11];
            decode.imm = {{21{w[10]}}, w[10:0]};
        end
        decode.v  = 1'b1;
        decode.pc = pc;
    endfunction : decode

    // Youngest producer wins
    function automatic logic [31:0] fwd(input logic [4:0] idx, input fspc_stg_s m,
                                        input logic [31:0] mv, input fspc_stg_s a,
                                        input logic [31:0] av, input logic [31:0] rfv);
        if (idx == 5'h00) begin
            fwd = 32'h00000000;
        end else if (m.v && writes(m.op) && m.rd == idx) begin
            fwd = mv; // [RULE2]
        end else if (a.v && writes(a.op) && a.rd == idx) begin
            fwd = av; // [RULE2]
        end else begin
            fwd = rfv;
        end
    endfunction : fwd

    logic [31:0] ctrl_reg;
    logic        brk_reg;
    logic [31:0] bka_reg;
    logic [31:0] bkd_reg;
    logic [31:0] fva_reg;
    logic [31:0] fpa_reg;
    logic [31:0] ipc_reg;
    logic        iok_reg;
    logic [31:0] ihold_reg;
    logic        ihv_reg;
    fspc_dec_s   e_reg;
    fspc_stg_s   m_reg;
    fspc_stg_s   a_reg;
    fspc_stg_s   w_reg;
    logic [31:0] rf_reg [32];
    fspc_mdst_e  md_st_reg;
    logic [5:0]  md_cnt_reg;
    fspc_op_e    md_op_reg;
    logic [31:0] md_a_reg;
    logic [31:0] md_b_reg;
    logic [31:0] hi_reg;
    logic [31:0] lo_reg;
    logic        ah_v_reg;
    logic        ah_wr_reg;
    logic [7:0]  ah_addr_reg;

    logic        run;
    fspc_mode_e  mode;
    fspc_dec_s   dec;
    logic [31:0] rfa;
    logic [31:0] rfb;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] mv;
    logic [31:0] av;
    logic [31:0] ld_sh;
    logic [31:0] alu;
    logic [31:0] va;
    logic        taken;
    logic [31:0] nva;
    logic        ldu;
    logic        md_free;
    logic        is_md;
    logic        stall_e;
    logic [5:0]  md_cnt_next;
    logic [63:0] md_prod;
    logic        brk_hit;
    logic        ah_go;

    assign run  = ctrl_reg[`FSPC_CTRL_RUN];
    assign mode = fspc_mode_e'(ctrl_reg[`FSPC_CTRL_MODE_HI:`FSPC_CTRL_MODE_LO]);

    // Fetch: a held copy covers stalls, since the SRAM already moved on
    assign dec = decode(ihv_reg ? ihold_reg : I_RDATA, ctrl_reg[`FSPC_CTRL_CMPT],
                        ctrl_reg[`FSPC_CTRL_BASE], ipc_reg); // [RULE3]

    // Register reads with write-through
    assign rfa = (w_reg.v && writes(w_reg.op) && w_reg.rd == e_reg.rs) ? w_reg.res
                                                                        : rf_reg[e_reg.rs];
    assign rfb = (w_reg.v && writes(w_reg.op) && w_reg.rd == e_reg.rt) ? w_reg.res
                                                                        : rf_reg[e_reg.rt];
    assign mv  = (m_reg.op == OP_MULG) ? 32'(m_reg.res * m_reg.opb) : m_reg.res; // [RULE11]
    assign ld_sh = D_RDATA >> {a_reg.addr[1:0], 3'b000};
    assign opa = fwd(e_reg.rs, m_reg, mv, a_reg, av, rfa); // [RULE6]
    assign opb = fwd(e_reg.rt, m_reg, mv, a_reg, av, rfb); // [RULE6]

    // Load alignment and sign extension
    always_comb begin
        case (a_reg.op)
            OP_LW:   av = D_RDATA; // [RULE18]
            OP_LH:   av = {{16{ld_sh[15]}}, ld_sh[15:0]}; // [RULE18]
            OP_LB:   av = {{24{ld_sh[7]}}, ld_sh[7:0]}; // [RULE18]
            default: av = a_reg.res; // [RULE21]
        endcase
    end

    // Execute: ALU, address, branch, next fetch
    assign va    = opa + e_reg.imm; // [RULE7]
    assign taken = e_reg.v && !stall_e && ((e_reg.op == OP_BEQ && opa == opb) ||
                   (e_reg.op == OP_BNE && opa != opb)); // [RULE8]
    assign nva   = taken ? e_reg.pc + 32'h00000004 + {e_reg.imm[29:0], 2'b00}
                         : fva_reg + 32'h00000004; // [RULE8] [RULE9]
    always_comb begin
        case (e_reg.op)
            OP_ADD:  alu = opa + opb;
            OP_SUB:  alu = opa - opb;
            OP_AND:  alu = opa & opb;
            OP_OR:   alu = opa | opb;
            OP_ADDI: alu = va;
            OP_MFHI: alu = hi_reg;
            OP_MFLO: alu = lo_reg;
            default: alu = opa;
        endcase
    end

    // Interlocks stop fetch and execute only
    assign ldu     = m_reg.v && is_load(m_reg.op) && m_reg.rd != 5'h00 &&
                     (m_reg.rd == e_reg.rs || m_reg.rd == e_reg.rt);
    assign is_md   = e_reg.op inside {OP_MULT, OP_MAC, OP_DIV};
    assign md_free = (md_st_reg == MS_IDLE) || (md_st_reg == MS_ALIGN);
    assign stall_e = !run || (e_reg.v && (ldu || (is_md && !md_free) ||
                     ((e_reg.op == OP_MFHI || e_reg.op == OP_MFLO) && md_st_reg != MS_IDLE)));

    // Extra muldiv_unit memory clocks
    always_comb begin
        md_cnt_next = 6'h00; // [RULE12]
        if (e_reg.op == OP_DIV) begin
            md_cnt_next = `FSPC_DIV_MAX; // [RULE16]
            if (mode != MD_AREA) begin
                if (opa[31:8] == 24'h000000) begin
                    md_cnt_next = `FSPC_DIV_MAX - `FSPC_SKIP_3B; // [RULE17]
                end else if (opa[31:16] == 16'h0000) begin
                    md_cnt_next = `FSPC_DIV_MAX - `FSPC_SKIP_2B; // [RULE17]
                end else if (opa[31:24] == 8'h00) begin
                    md_cnt_next = `FSPC_DIV_MAX - `FSPC_SKIP_1B; // [RULE17]
                end
            end
        end else if (mode == MD_AREA) begin
            md_cnt_next = (e_reg.op == OP_MAC) ? `FSPC_AREA_MAC
                                               : `FSPC_AREA_MUL; // [RULE14] [RULE15]
        end else if (mode == MD_HIPERF && opb[31:16] != 16'h0000) begin
            md_cnt_next = `FSPC_HP_MUL32; // [RULE13]
        end
    end

    // Fetch address registers
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            fva_reg <= `FSPC_BOOT_PC;
            fpa_reg <= xlate(`FSPC_BOOT_PC);
            ipc_reg <= `FSPC_BOOT_PC;
            iok_reg <= 1'b0;
        end else if (!stall_e) begin
            ipc_reg <= fva_reg;
            iok_reg <= !taken; // In-flight word dropped
            fva_reg <= nva; // [RULE9]
            fpa_reg <= xlate(nva); // [RULE9]
        end
    end

    // Instruction hold across stalls
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            ihv_reg   <= 1'b0;
            ihold_reg <= 32'h00000000;
        end else if (!stall_e) begin
            ihv_reg <= 1'b0;
        end else if (!ihv_reg) begin
            ihv_reg   <= 1'b1;
            ihold_reg <= I_RDATA;
        end
    end

    // Fetch to execute
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            e_reg <= '0;
        end else if (!stall_e) begin
            e_reg   <= dec; // [RULE1]
            e_reg.v <= iok_reg && !taken;
        end
    end

    // Later stages never stall
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            m_reg <= '0;
            a_reg <= '0;
            w_reg <= '0;
        end else begin
            m_reg.v    <= e_reg.v && !stall_e; // [RULE1]
            m_reg.op   <= e_reg.op;
            m_reg.rd   <= e_reg.rd;
            m_reg.res  <= alu;
            m_reg.addr <= xlate(va); // [RULE7]
            m_reg.opb  <= opb;
            a_reg      <= m_reg; // [RULE1]
            a_reg.res  <= mv; // [RULE21]
            w_reg      <= a_reg; // [RULE1]
            w_reg.res  <= av;
        end
    end

    // Data SRAM access from memory stage
    assign D_REQ   = m_reg.v && (is_load(m_reg.op) || m_reg.op == OP_SW); // [RULE11]
    assign D_WE    = m_reg.v && m_reg.op == OP_SW;
    assign D_BE    = 4'hF;
    assign D_ADDR  = m_reg.addr;
    assign D_WDATA = m_reg.opb;
    assign I_ADDR  = fpa_reg; // [RULE3]

    // Register file; entry zero stays zero
    generate
        for (genvar g = 0; g < 32; g++) begin : g_rf
            always_ff @(posedge MCLK) begin
                if (!RESET_N) begin
                    rf_reg[g] <= 32'h00000000;
                end else if (g != 0 && w_reg.v && writes(w_reg.op) &&
                             w_reg.rd == 5'(g)) begin
                    rf_reg[g] <= w_reg.res; // [RULE23] [RULE21]
                end
            end
        end
    endgenerate

    // muldiv_unit runs on through integer stalls
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            md_st_reg  <= MS_IDLE;
            md_cnt_reg <= 6'h00;
            md_op_reg  <= OP_NOP;
            md_a_reg   <= 32'h00000000;
            md_b_reg   <= 32'h00000000;
        end else begin
            case (md_st_reg)
                MS_MEM: begin
                    if (md_cnt_reg == 6'h00) begin
                        md_st_reg <= MS_ALIGN; // [RULE24]
                    end else begin
                        md_cnt_reg <= md_cnt_reg - 6'h01; // [RULE13] [RULE14]
                    end
                end
                default: md_st_reg <= MS_IDLE;
            endcase
            if (e_reg.v && is_md && !stall_e) begin
                md_st_reg  <= MS_MEM; // [RULE10]
                md_cnt_reg <= md_cnt_next;
                md_op_reg  <= e_reg.op;
                md_a_reg   <= opa;
                md_b_reg   <= opb;
            end
        end
    end

    // Result pair written as the operation leaves align
    assign md_prod = {32'h00000000, md_a_reg} * {32'h00000000, md_b_reg};
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            hi_reg <= 32'h00000000;
            lo_reg <= 32'h00000000;
        end else if (md_st_reg == MS_ALIGN) begin
            case (md_op_reg)
                OP_MAC:  {hi_reg, lo_reg} <= {hi_reg, lo_reg} + md_prod; // [RULE19] [RULE20]
                OP_DIV: begin
                    // Divide by zero leaves a defined pattern, no trap
                    hi_reg <= (md_b_reg == 32'h0) ? md_a_reg : md_a_reg % md_b_reg; // [RULE19]
                    lo_reg <= (md_b_reg == 32'h0) ? 32'hFFFFFFFF : md_a_reg / md_b_reg;
                end
                default: {hi_reg, lo_reg} <= md_prod; // [RULE19] [RULE20]
            endcase
        end
    end
    assign MDU_BUSY = md_st_reg != MS_IDLE;

    // Complex breakpoint on address and data in align
    assign brk_hit = ctrl_reg[`FSPC_CTRL_BKEN] && a_reg.v &&
                     (is_load(a_reg.op) || a_reg.op == OP_SW) && a_reg.addr == bka_reg &&
                     ((a_reg.op == OP_SW) ? a_reg.opb : av) == bkd_reg; // [RULE22]

    // Bus slave: zero wait, always OKAY
    assign ah_go     = HSEL && HTRANS[1] && HREADY;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            ah_v_reg    <= 1'b0;
            ah_wr_reg   <= 1'b0;
            ah_addr_reg <= 8'h00;
            HRDATA      <= 32'h00000000;
        end else begin
            ah_v_reg    <= ah_go;
            ah_wr_reg   <= HWRITE;
            ah_addr_reg <= HADDR[7:0];
            // Read data taken at address phase
            if (ah_go && !HWRITE && HADDR[31:8] == 24'h000000) begin
                case (HADDR[7:0])
                    `FSPC_CTRL_OFS: HRDATA <= ctrl_reg;
                    `FSPC_STAT_OFS: HRDATA <= {29'h0, stall_e, MDU_BUSY, brk_reg};
                    `FSPC_PC_OFS:   HRDATA <= e_reg.pc;
                    `FSPC_BKA_OFS:  HRDATA <= bka_reg;
                    `FSPC_BKD_OFS:  HRDATA <= bkd_reg;
                    `FSPC_HI_OFS:   HRDATA <= hi_reg;
                    `FSPC_LO_OFS:   HRDATA <= lo_reg;
                    default:        HRDATA <= 32'h00000000;
                endcase
            end
        end
    end

    // Register writes in the data phase; a new hit beats a clear
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            ctrl_reg <= `FSPC_CTRL_RST;
            bka_reg  <= 32'h00000000;
            bkd_reg  <= 32'h00000000;
            brk_reg  <= 1'b0;
        end else begin
            brk_reg <= brk_hit || (brk_reg && !(ah_v_reg && ah_wr_reg &&
                       ah_addr_reg == `FSPC_STAT_OFS && HWDATA[`FSPC_STAT_BRK]));
            if (ah_v_reg && ah_wr_reg) begin
                case (ah_addr_reg)
                    `FSPC_CTRL_OFS: ctrl_reg <= {26'h0, HWDATA[5:0]};
                    `FSPC_BKA_OFS:  bka_reg  <= HWDATA;
                    `FSPC_BKD_OFS:  bkd_reg  <= HWDATA;
                    default:        ;
                endcase
            end
        end
    end
    assign BREAK_FLAG = brk_reg;
endmodule : fspc_top

// >>> tb/fspc_checker.sv
// Port assertions for the pipeline control
`timescale 1ns/1ps
module fspc_checker (
    input wire logic        MCLK,
    input wire logic        RESET_N,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic [31:0] I_ADDR,
    input wire logic        D_REQ,
    input wire logic [3:0]  D_BE,
    input wire logic        MDU_BUSY
);
    localparam int MAX_BUSY = 41;
    logic [7:0] busy_cnt;
    logic       rd_req;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // Busy run length; margin of one for the align slot
    always_ff @(posedge MCLK) begin
        if (!RESET_N || !MDU_BUSY) busy_cnt <= 8'h00;
        else busy_cnt <= busy_cnt + 8'h01;
    end
    assign rd_req = HSEL && HTRANS[1] && HREADY && !HWRITE;
    chk_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus not OKAY");
    chk_reset_quiet: assert property ($rose(RESET_N) |-> I_ADDR == 32'h0 && !D_REQ && !MDU_BUSY)
        else $error("not idle after reset");
    chk_fetch_word: assert property (I_ADDR[1:0] == 2'b00)
        else $error("fetch misaligned");
    chk_data_lanes: assert property (D_REQ |-> D_BE == 4'hF)
        else $error("lanes missing");
    chk_mdu_align: assert property ($rose(MDU_BUSY) |-> MDU_BUSY[*2])
        else $error("align slot skipped");
    chk_mdu_bound: assert property (busy_cnt < MAX_BUSY)
        else $error("busy too long");
    chk_read_hold: assert property (!rd_req |=> $stable(HRDATA))
        else $error("read data moved");
    chk_unmapped_zero: assert property (rd_req && HADDR > 32'h18 |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
endmodule : fspc_checker

// >>> tb/fspc_sram_model.sv
// Sync instruction and data SRAM model
`timescale 1ns/1ps
module fspc_sram_model (
    input  wire logic        clk,
    input  wire logic [31:0] prog [0:63],
    input  wire logic [31:0] i_addr,
    output logic      [31:0] i_rdata,
    input  wire logic        d_req,
    input  wire logic        d_we,
    input  wire logic [31:0] d_addr,
    input  wire logic [31:0] d_wdata,
    output logic      [31:0] d_rdata
);
    logic [31:0] dmem [0:63];
    logic [31:0] st_addr;
    logic [31:0] st_data;
    initial d_rdata = 32'h5A5A5A5A;
    // Word of last cycle's fetch address
    always @(posedge clk) i_rdata <= prog[i_addr[7:2]];
    // Data only after a request; otherwise a changing pattern
    always @(posedge clk) begin
        d_rdata <= d_req ? dmem[d_addr[7:2]] : ~d_rdata;
        if (d_req && d_we) begin
            dmem[d_addr[7:2]] <= d_wdata;
            st_addr <= d_addr;
            st_data <= d_wdata;
        end
    end
endmodule : fspc_sram_model

// >>> tb/tb_top.sv
// Bench: bypass, store, muldiv stalls, bus registers
`timescale 1ns/1ps
module tb_top;
    import fspc_pkg::*;
    logic        MCLK, RESET_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
    logic        D_REQ, D_WE, BREAK_FLAG, MDU_BUSY;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    logic [3:0]  D_BE;
    logic [31:0] HADDR, HWDATA, HRDATA, I_ADDR, I_RDATA, D_ADDR, D_WDATA, D_RDATA;
    logic [31:0] prog [0:63];
    logic [31:0] seed, rd_val, a_val, b_val;
    int          failures = 0, checked = 0, cycles = 0, run_len = 0, last_run, base_run;
    fspc_mode_e  modes [7] = '{MD_DSP, MD_HIPERF, MD_AREA, MD_AREA, MD_AREA, MD_HIPERF, MD_DSP};
    fspc_op_e    ops [7] = '{OP_MULT, OP_MULT, OP_MULT, OP_MAC, OP_DIV, OP_DIV, OP_DIV};
    assign HREADY = HREADYOUT;
    fspc_top fspc_top_inst (.MCLK(MCLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
        .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .I_ADDR(I_ADDR),
        .I_RDATA(I_RDATA), .D_REQ(D_REQ), .D_WE(D_WE), .D_BE(D_BE), .D_ADDR(D_ADDR),
        .D_WDATA(D_WDATA), .D_RDATA(D_RDATA), .BREAK_FLAG(BREAK_FLAG), .MDU_BUSY(MDU_BUSY));
    fspc_sram_model fspc_sram_model_inst (.clk(MCLK), .prog(prog), .i_addr(I_ADDR),
        .i_rdata(I_RDATA), .d_req(D_REQ), .d_we(D_WE), .d_addr(D_ADDR), .d_wdata(D_WDATA),
        .d_rdata(D_RDATA));
    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [31:0] enc(input fspc_op_e op, input int rd, rs, rt,
                                        input logic [10:0] imm);
        return {op, rd[4:0], rs[4:0], rt[4:0], imm};
    endfunction : enc
    // Expected extra stall clocks
    function automatic int extra(input fspc_mode_e m, input fspc_op_e op, input logic [31:0] a);
        if (op == OP_DIV) begin
            if (m == MD_AREA) return 38;
            return a[31:8] == 0 ? 15 : a[31:16] == 0 ? 23 : a[31:24] == 0 ? 31 : 38;
        end
        if (m == MD_AREA) return op == OP_MAC ? 33 : 31;
        return (m == MD_HIPERF && op == OP_MULT && a[31:16] != 0) ? 1 : 0;
    endfunction : extra
    task automatic check(input string what, input logic [63:0] exp, got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    // One word transfer; idle edge first
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        @(posedge MCLK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= addr;
        HWRITE <= wr;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= wdata;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        rd_val = HRDATA;
    endtask : bus
    // Bypassed adds, store, one muldiv op, spin
    task automatic run_case(input fspc_mode_e m, input fspc_op_e op, input int k,
                            input logic [9:0] a0, input logic [9:0] b0);
        logic [63:0] prod;
        @(posedge MCLK);
        RESET_N <= 1'b0;
        for (int i = 0; i < 64; i++) prog[i] <= 32'h0;
        repeat (6) @(posedge MCLK);
        a_val = 32'(a0) << k;
        b_val = 32'(b0);
        prog[0] <= enc(OP_ADDI, 1, 0, 0, {1'b0, a0});
        for (int i = 1; i <= k; i++) prog[i] <= enc(OP_ADD, 1, 1, 1, 11'h000);
        prog[k + 1] <= enc(OP_ADDI, 2, 0, 0, {1'b0, b0});
        prog[k + 2] <= enc(OP_SW, 1, 0, 1, 11'h020);
        prog[k + 3] <= enc(op, 0, 1, op == OP_MULT ? 1 : 2, 11'h000);
        prog[k + 4] <= enc(OP_BEQ, 0, 0, 0, 11'h7FF);
        RESET_N <= 1'b1;
        bus(1'b0, 32'h00, 32'h0);
        check("ctrl_reset", 32'h0000000A, rd_val);
        bus(1'b0, 32'h40, 32'h0);
        check("unmapped", 32'h0, rd_val);
        last_run = 0;
        bus(1'b1, 32'h00, {27'h0, m, 3'b011});
        for (int w = 0; w < 300 && last_run == 0; w++) @(posedge MCLK);
        if (op == OP_MULT && m == MD_DSP) base_run = last_run;
        check("stall", 64'(extra(m, op, a_val)), 64'(last_run - base_run));
        check("store_addr", 32'h40000020, fspc_sram_model_inst.st_addr);
        check("store_data", a_val, fspc_sram_model_inst.st_data);
        prod = op == OP_DIV ? {a_val % b_val, a_val / b_val} : 64'(a_val) * 64'(a_val);
        if (op != OP_MAC) begin
            bus(1'b0, 32'h14, 32'h0);
            check("hi", prod[63:32], rd_val);
            bus(1'b0, 32'h18, 32'h0);
            check("lo", prod[31:0], rd_val);
        end
        $display("case %0d %0h %0d", m, op, last_run);
    endtask : run_case
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Busy run length at run end
    always @(posedge MCLK) begin
        if (MDU_BUSY === 1'b1) run_len++;
        else if (run_len != 0) begin
            last_run = run_len;
            run_len = 0;
        end
    end
    // Hang guard, ~8x the expected run
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        HSEL = 1'b0;
        HTRANS = 2'b00;
        HADDR = 32'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = 32'h0;
        RESET_N = 1'b0;
        seed = 32'h56D203F4;
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 7; c++) begin
                seed = lfsr(seed);
                run_case(modes[c], ops[c], r == 0 ? 7 : r == 1 ? 0 : int'(seed[2:0]),
                         r == 0 ? 10'h3FF : r == 1 ? {3'h0, seed[9:3]} : seed[12:3],
                         seed[22:13] | 10'h001);
            end
        end
        summarize();
    end
endmodule : tb_top
bind fspc_top fspc_checker fspc_checker_inst (.MCLK(MCLK), .RESET_N(RESET_N), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .I_ADDR(I_ADDR), .D_REQ(D_REQ),
    .D_BE(D_BE), .MDU_BUSY(MDU_BUSY));
